// >>> rtl/aperture_sync_defs.svh
`ifndef APERTURE_SYNC_DEFS_SVH
`define APERTURE_SYNC_DEFS_SVH
// Notes on behaviour
// R1 - Fine code adds straight-binary sampling delay
// R2 - No aperture adjust in dual-edge above 1600 MHz
// R3 - Avoid maximum delay at maximum sampling rate
// R4 - Software writes reserved bits with reset values
// R5 - Reference delay linear to 319, then saturates
// R6 - Clock-phase dual mode needs mode bits 000
// R7 - Phase select picks latched reference clock phase
// R8 - Slave bit aligns divider to master reference
// R9 - Clear disable bit to drive CLK/4 outputs
// R10 - Gate bit enables output clock realign input; here a set gate bit blocks the input instead
// R11 - Reserved word reads fixed power-on value
// R12 - Adjust select enables fine delay effect
// R13 - Writes to read-only word are ignored

// Register indices; byte address is four times the index
`define FINE_IDX        8'h0D
`define SYNC_IDX        8'h0E
`define RSVD_IDX        8'h0F
`define STAT_IDX        8'h10

// Reset values and writable bit masks
`define FINE_RST        16'h0000
`define SYNC_RST        16'h0003
`define RSVD_VAL        16'h001D
`define FINE_WMASK      16'hFC00
`define SYNC_WMASK      16'hFFDF

// Field positions
`define FINE_MSB        15
`define FINE_LSB        10
`define RCD_MSB         15
`define RCD_LSB         7
`define DUAL_MODE_BIT   6
`define PHASE_MSB       4
`define PHASE_LSB       3
`define SLAVE_BIT       2
`define OUT_DIS_BIT     1
`define GATE_BIT        0

// Delay scaling: fine code 63 is 2300 fs, reference code 319 is 1200 ps
`define FINE_MAX_CODE   32'h0000003F
`define FINE_MAX_FS     32'h000008FC
`define REF_DLY_FULL    9'h13F
`define REF_DLY_MAX_PS  11'h4B0

// Mode bits of address 0h that allow the clock-phase dual mode
`define DES_SEL_CLKIQ   3'h0
`endif

// >>> rtl/aperture_sync_pkg.sv
package aperture_sync_pkg;
  typedef enum logic [1:0] {
    PHASE_0   = 2'b00,
    PHASE_90  = 2'b01,
    PHASE_180 = 2'b10,
    PHASE_270 = 2'b11
  } phase_type;

  typedef enum logic [1:0] {
    ALIGN_IDLE   = 2'b00,
    ALIGN_WAIT   = 2'b01,
    ALIGN_LOCKED = 2'b10
  } align_state_type;
endpackage

// >>> rtl/sync_cfg_if.sv
interface sync_cfg_if;
  import aperture_sync_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       out_disable;
  logic       slave;
  phase_type  phase_sel;
  logic       realign;
  logic       ref_in;
  logic       aligned;
  logic [1:0] div_phase;
  logic       ref_out;

  modport cfg (output clk, rst_n, out_disable, slave, phase_sel, realign, ref_in,
               input aligned, div_phase, ref_out);
  modport gen (input clk, rst_n, out_disable, slave, phase_sel, realign, ref_in,
               output aligned, div_phase, ref_out);
endinterface

// >>> rtl/ref_clock_gen.sv
module ref_clock_gen
(
  sync_cfg_if.gen cfg
);
  import aperture_sync_pkg::*;

  logic            ref_prev_ff;
  logic            role_prev_ff;
  logic [1:0]      div_cnt_ff;
  logic            ref_out_ff;
  logic            ref_rise;
  align_state_type state_ff;
  align_state_type nxt_state;

  // Rising edge of the already synchronised reference
  assign ref_rise = cfg.ref_in & ~ref_prev_ff;

  // Edge and role history
  always_ff @(posedge cfg.clk or negedge cfg.rst_n)
  begin
    if (!cfg.rst_n)
    begin
      ref_prev_ff  <= 1'b0;
      role_prev_ff <= 1'b0;
    end
    else
    begin
      ref_prev_ff  <= cfg.ref_in;
      role_prev_ff <= cfg.slave;
    end
  end

  // Divide-by-four counter, realigned by pin or by master reference
  always_ff @(posedge cfg.clk or negedge cfg.rst_n)
  begin
    if (!cfg.rst_n)
      div_cnt_ff <= 2'h0;
    else if (cfg.realign)
      div_cnt_ff <= 2'h0; // R10
    else if (cfg.slave && ref_rise)
      div_cnt_ff <= cfg.phase_sel; // R7 R8
    else
      div_cnt_ff <= div_cnt_ff + 2'h1;
  end

  // CLK/4 output, held low while the drivers are disabled
  always_ff @(posedge cfg.clk or negedge cfg.rst_n)
  begin
    if (!cfg.rst_n)
      ref_out_ff <= 1'b0;
    else
      ref_out_ff <= ~cfg.out_disable & div_cnt_ff[1]; // R9
  end

  // Alignment tracking: a slave waits for the first master edge
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ALIGN_IDLE:   nxt_state = cfg.slave ? ALIGN_WAIT : ALIGN_LOCKED;
      ALIGN_WAIT:
      begin
        if (!cfg.slave)
          nxt_state = ALIGN_IDLE;
        else if (ref_rise)
          nxt_state = ALIGN_LOCKED; // R8
      end
      ALIGN_LOCKED:
      begin
        if (cfg.realign || (cfg.slave != role_prev_ff))
          nxt_state = ALIGN_IDLE;
      end
      default:      nxt_state = ALIGN_IDLE;
    endcase
  end

  always_ff @(posedge cfg.clk or negedge cfg.rst_n)
  begin
    if (!cfg.rst_n)
      state_ff <= ALIGN_IDLE;
    else
      state_ff <= nxt_state;
  end

  assign cfg.aligned   = (state_ff == ALIGN_LOCKED);
  assign cfg.div_phase = div_cnt_ff;
  assign cfg.ref_out   = ref_out_ff;

  // Slave load takes the selected phase
  property p_slave_load;
    @(posedge cfg.clk) disable iff (!cfg.rst_n)
    (cfg.slave && ref_rise && !cfg.realign) |=> (div_cnt_ff == $past(cfg.phase_sel));
  endproperty
  a_slave_load: assert property (p_slave_load) // R7
    else $error("divider did not load selected phase");

  // Disabled drivers stay low
  property p_out_off;
    @(posedge cfg.clk) disable iff (!cfg.rst_n)
    cfg.out_disable |=> !ref_out_ff;
  endproperty
  a_out_off: assert property (p_out_off) // R9
    else $error("reference output toggled while disabled");
endmodule

// >>> rtl/aperture_sync_regs.sv
`include "aperture_sync_defs.svh"

module aperture_sync_regs
(
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         aperture_adjust_select,
  input  wire logic [2:0]                   mode_select_bits,
  input  wire logic                         ref_clock_in,
  input  wire logic                         output_clock_realign_input,
  output logic [5:0]                        fine_aperture_delay,
  output logic [11:0]                       fine_delay_fs,
  output logic [8:0]                        ref_clock_delay,
  output logic [10:0]                       ref_delay_ps,
  output logic                              clock_phase_dual_channel_mode,
  output aperture_sync_pkg::phase_type      phase_select,
  output logic                              slave_enable,
  output logic                              ref_clock_out_disable,
  output logic                              clock_realign_gate,
  output logic                              realign_pulse,
  output logic                              sync_ref_clock_out_a,
  output logic                              sync_ref_clock_out_b,
  output logic                              ref_out_drive_n,
  output logic                              divider_aligned
);
  import aperture_sync_pkg::*;

  logic        rst_s1_ff;
  logic        rst_s2_ff;
  logic        rst_n;
  logic        ref_s1_ff;
  logic        ref_s2_ff;
  logic        rln_s1_ff;
  logic        rln_s2_ff;
  logic        rln_s3_ff;
  logic [15:0] fine_reg_ff;
  logic [15:0] sync_reg_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [5:0]  fine_delay_ff;
  logic [11:0] fine_fs_ff;
  logic [8:0]  ref_code_ff;
  logic [10:0] ref_ps_ff;
  logic        dual_mode_ff;
  logic [15:0] rd_word;
  logic [8:0]  ref_field;
  logic [8:0]  ref_sat;
  logic [5:0]  fine_field;
  logic [5:0]  fine_eff;
  logic        wr_en;
  logic        rd_setup;
  logic        setup;
  logic [5:0]  wdata_fine;
  logic [1:0]  wdata_phase;
  logic        wdata_slave;

  sync_cfg_if cfg_bus ();

  // Address decode for one aligned 32-bit word
  function automatic logic is_reg(input logic [11:0] a, input logic [7:0] idx);
    return (a[11:10] == 2'h0) && (a[1:0] == 2'h0) && (a[9:2] == idx);
  endfunction

  // Any register that answers on the bus
  function automatic logic is_mapped(input logic [11:0] a);
    return is_reg(a, `FINE_IDX) || is_reg(a, `SYNC_IDX) ||
           is_reg(a, `RSVD_IDX) || is_reg(a, `STAT_IDX);
  endfunction

  // Fine code to femtoseconds, straight binary
  function automatic logic [11:0] fine_to_fs(input logic [5:0] c);
    int unsigned p;
    p = c * `FINE_MAX_FS / `FINE_MAX_CODE;
    return p[11:0];
  endfunction

  // Saturated reference code to picoseconds
  function automatic logic [10:0] ref_to_ps(input logic [8:0] c);
    int unsigned p;
    p = c * 32'(`REF_DLY_MAX_PS) / 32'(`REF_DLY_FULL);
    return p[10:0];
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  assign rst_n = rst_s2_ff;

  // Pin synchronisers; logic reads the second stage, and the third stage too for the realign edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      rln_s1_ff <= 1'b0;
      rln_s2_ff <= 1'b0;
      rln_s3_ff <= 1'b0;
    end
    else
    begin
      ref_s1_ff <= ref_clock_in;
      ref_s2_ff <= ref_s1_ff;
      rln_s1_ff <= output_clock_realign_input;
      rln_s2_ff <= rln_s1_ff;
      rln_s3_ff <= rln_s2_ff;
    end
  end

  // Realign request counts only while the gate bit is cleared
  assign realign_pulse = rln_s2_ff & ~rln_s3_ff & ~sync_reg_ff[`GATE_BIT]; // R10

  // Bus phases; zero wait states
  assign setup     = psel & ~penable;
  assign rd_setup  = setup & ~pwrite;
  assign wr_en     = psel & penable & pwrite;
  assign pready    = psel & penable;
  assign prdata    = prdata_ff;
  assign pslverr   = pslverr_ff;

  // Helper slices of write data
  assign wdata_fine  = pwdata[`FINE_MSB:`FINE_LSB];
  assign wdata_phase = pwdata[`PHASE_MSB:`PHASE_LSB];
  assign wdata_slave = pwdata[`SLAVE_BIT];

  // Fine delay register; reserved bits are kept at zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fine_reg_ff <= `FINE_RST;
    else if (wr_en && is_reg(paddr, `FINE_IDX))
      fine_reg_ff <= pwdata[15:0] & `FINE_WMASK; // R1
  end

  // Synchronisation control register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sync_reg_ff <= `SYNC_RST;
    else if (wr_en && is_reg(paddr, `SYNC_IDX))
      sync_reg_ff <= pwdata[15:0] & `SYNC_WMASK; // R5 R6 R7 R8 R9 R10
  end

  // Read multiplexer; the read-only word has no storage to write
  always_comb
  begin
    rd_word = 16'h0000;
    if (is_reg(paddr, `FINE_IDX))
      rd_word = fine_reg_ff;
    else if (is_reg(paddr, `SYNC_IDX))
      rd_word = sync_reg_ff;
    else if (is_reg(paddr, `RSVD_IDX))
      rd_word = `RSVD_VAL; // R11 R13
    else if (is_reg(paddr, `STAT_IDX))
      rd_word = {12'h000, dual_mode_ff, cfg_bus.div_phase, cfg_bus.aligned};
  end

  // Read data and error answer are captured in the setup cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else if (setup)
    begin
      prdata_ff  <= rd_setup ? {16'h0000, rd_word} : 32'h00000000;
      pslverr_ff <= ~is_mapped(paddr);
    end
  end

  // Field views
  assign fine_field = fine_reg_ff[`FINE_MSB:`FINE_LSB];
  assign ref_field  = sync_reg_ff[`RCD_MSB:`RCD_LSB];
  assign fine_eff   = aperture_adjust_select ? fine_field : 6'h00; // R1 R12
  assign ref_sat    = (ref_field >= `REF_DLY_FULL) ? `REF_DLY_FULL : ref_field; // R5

  // Effective fine delay, applied only with adjust selected
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fine_delay_ff <= 6'h00;
      fine_fs_ff    <= 12'h000;
    end
    else
    begin
      fine_delay_ff <= fine_eff; // R1 R12
      fine_fs_ff    <= fine_to_fs(fine_eff); // R1
    end
  end

  // Reference clock input delay, saturating at full scale
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_code_ff <= 9'h000;
      ref_ps_ff   <= 11'h000;
    end
    else
    begin
      ref_code_ff <= ref_sat; // R5
      ref_ps_ff   <= ref_to_ps(ref_sat); // R5
    end
  end

  // Clock-phase dual mode needs the mode bits of address 0h cleared
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      dual_mode_ff <= 1'b0;
    else
      dual_mode_ff <= sync_reg_ff[`DUAL_MODE_BIT] && (mode_select_bits == `DES_SEL_CLKIQ); // R6
  end

  // Controls handed to the divider and output driver
  assign cfg_bus.clk         = mclk;
  assign cfg_bus.rst_n       = rst_n;
  assign cfg_bus.out_disable = sync_reg_ff[`OUT_DIS_BIT];
  assign cfg_bus.slave       = sync_reg_ff[`SLAVE_BIT];
  assign cfg_bus.phase_sel   = phase_type'(sync_reg_ff[`PHASE_MSB:`PHASE_LSB]);
  assign cfg_bus.realign     = realign_pulse;
  assign cfg_bus.ref_in      = ref_s2_ff;

  ref_clock_gen u_gen (
    .cfg (cfg_bus.gen)
  );

  // Output assignments
  assign fine_aperture_delay           = fine_delay_ff;
  assign fine_delay_fs                 = fine_fs_ff;
  assign ref_clock_delay               = ref_code_ff;
  assign ref_delay_ps                  = ref_ps_ff;
  assign clock_phase_dual_channel_mode = dual_mode_ff;
  assign phase_select                  = phase_type'(sync_reg_ff[`PHASE_MSB:`PHASE_LSB]); // R7
  assign slave_enable                  = sync_reg_ff[`SLAVE_BIT]; // R8
  assign ref_clock_out_disable         = sync_reg_ff[`OUT_DIS_BIT];
  assign clock_realign_gate            = sync_reg_ff[`GATE_BIT];
  assign sync_ref_clock_out_a          = cfg_bus.ref_out; // R9
  assign sync_ref_clock_out_b          = cfg_bus.ref_out; // R9
  assign ref_out_drive_n               = sync_reg_ff[`OUT_DIS_BIT];
  assign divider_aligned               = cfg_bus.aligned;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // A fine write shows two cycles later while adjust stays selected
  property p_fine_write;
    (wr_en && is_reg(paddr, `FINE_IDX) && aperture_adjust_select) ##1 aperture_adjust_select
      |=> (fine_aperture_delay == $past(wdata_fine, 2));
  endproperty
  a_fine_write: assert property (p_fine_write) // R1
    else $error("fine delay not applied after write");

  // Without adjust select no fine delay is applied
  property p_fine_gate;
    !aperture_adjust_select |=> (fine_aperture_delay == 6'h00) && (fine_delay_fs == 12'h000);
  endproperty
  a_fine_gate: assert property (p_fine_gate) // R12
    else $error("fine delay applied without adjust select");

  // Reference delay saturates at full scale
  property p_ref_sat;
    (ref_field >= `REF_DLY_FULL)
      |=> (ref_delay_ps == `REF_DLY_MAX_PS) && (ref_clock_delay == `REF_DLY_FULL);
  endproperty
  a_ref_sat: assert property (p_ref_sat) // R5
    else $error("reference delay not saturated");

  // Dual mode only with its bit set and mode bits cleared
  property p_dual;
    clock_phase_dual_channel_mode
      |-> $past(sync_reg_ff[`DUAL_MODE_BIT]) && ($past(mode_select_bits) == `DES_SEL_CLKIQ);
  endproperty
  a_dual: assert property (p_dual) // R6
    else $error("dual mode without its conditions");

  // Phase select follows the written code
  property p_phase;
    wr_en && is_reg(paddr, `SYNC_IDX) |=> (phase_select == $past(wdata_phase));
  endproperty
  a_phase: assert property (p_phase) // R7
    else $error("phase select not updated");

  // Role follows the written slave bit
  property p_slave;
    wr_en && is_reg(paddr, `SYNC_IDX) |=> (slave_enable == $past(wdata_slave));
  endproperty
  a_slave: assert property (p_slave) // R8
    else $error("slave role not updated");

  // Disabled drivers keep both outputs low
  property p_drivers;
    ref_clock_out_disable [*2] |-> !sync_ref_clock_out_a && !sync_ref_clock_out_b;
  endproperty
  a_drivers: assert property (p_drivers) // R9
    else $error("reference outputs driven while disabled");

  // No realign while the gate bit is set
  property p_realign;
    clock_realign_gate |-> !realign_pulse;
  endproperty
  a_realign: assert property (p_realign) // R10
    else $error("realign passed while gated");

  // Reserved word reads its fixed value without error
  property p_rsvd_read;
    (psel && penable && !pwrite && is_reg(paddr, `RSVD_IDX))
      |-> (prdata == {16'h0000, `RSVD_VAL}) && !pslverr;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) // R11
    else $error("reserved word read wrong value");

  // Writes to the reserved word change nothing
  property p_rsvd_write;
    wr_en && is_reg(paddr, `RSVD_IDX) |=> $stable(fine_reg_ff) && $stable(sync_reg_ff);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write) // R13
    else $error("write to read-only word changed state");
endmodule

// >>> tb/ref_master_model.sv
module ref_master_model
(
  input  wire logic mclk,
  input  wire logic run,
  output logic      ref_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] phase_ff;

  // Quarter-rate reference from the master, held low between frames
  always_ff @(posedge mclk)
  begin
    if (run)
      phase_ff <= phase_ff + 2'h1;
    else
      phase_ff <= 2'h0;
  end

  assign ref_clk = run & phase_ff[1];
endmodule

// >>> tb/aperture_delay_sync_regs_bench.sv
module aperture_delay_sync_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import aperture_sync_pkg::*;

  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic        adj_sel, realign_pin, ref_run, ref_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [2:0]  mode_bits;
  logic [5:0]  fine_code_o;
  logic [11:0] fine_fs_o;
  logic [8:0]  ref_dly_o;
  logic [10:0] ref_ps_o;
  logic        dual_o, slave_o, out_dis, gate_o, pulse_o, out_a, out_b, drive_n, aligned;
  phase_type   phase_o;
  logic [15:0] sdata;
  int          n_fail, n_compared, fcode, rcode, mb, adj, efine, ercd, hi, n, p0;
  int          n_pulse = 0;
  int          exp_q[$];
  int          ftab[4] = '{0, 63, 1, 62};
  int          rtab[6] = '{0, 319, 320, 511, 318, 1};

  aperture_sync_regs i_aperture_sync_regs (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aperture_adjust_select(adj_sel),
    .mode_select_bits(mode_bits), .ref_clock_in(ref_in),
    .output_clock_realign_input(realign_pin), .fine_aperture_delay(fine_code_o),
    .fine_delay_fs(fine_fs_o), .ref_clock_delay(ref_dly_o), .ref_delay_ps(ref_ps_o),
    .clock_phase_dual_channel_mode(dual_o), .phase_select(phase_o), .slave_enable(slave_o),
    .ref_clock_out_disable(out_dis), .clock_realign_gate(gate_o), .realign_pulse(pulse_o),
    .sync_ref_clock_out_a(out_a), .sync_ref_clock_out_b(out_b), .ref_out_drive_n(drive_n),
    .divider_aligned(aligned));

  ref_master_model i_ref_master_model (.mclk(mclk), .run(ref_run), .ref_clk(ref_in));

  // Free-running sampling clock, far below the rates that limit delay adjust
  always #12.5 mclk = ~mclk;

  // Count realign pulses seen at the clock edge
  always @(posedge mclk)
  begin
    if (pulse_o === 1'b1)
      n_pulse <= n_pulse + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_sim();
  end

  initial
  begin
    mclk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    adj_sel = 0; mode_bits = 0; realign_pin = 0; ref_run = 0; rnd = 32'h055d;
    n_fail = 0; n_compared = 0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    // Power-on contents and pin defaults
    apb(0, 12'h034, 0); chk(rd, 32'h0, "fine reset");
    apb(0, 12'h038, 0); chk(rd, 32'h3, "sync reset");
    chk({out_dis, gate_o, drive_n}, 3'b111, "disable defaults");
    apb(0, 12'h03C, 0); chk(rd, 32'h1D, "reserved word");
    apb(1, 12'h03C, 32'h0000FFFF); chk(err, 1'b0, "ro write error");
    apb(0, 12'h03C, 0); chk(rd, 32'h1D, "ro after write");
    apb(0, 12'h044, 0); chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    // Field sweep with boundary codes first, then random ones
    for (int i = 0; i < 12; i++)
    begin
      rnd = lfsr(rnd);
      fcode = (i < 4) ? ftab[i] : rnd[5:0];
      rcode = (i < 6) ? rtab[i] : rnd[14:6];
      sdata = {rcode[8:0], rnd[15], 1'b0, i[1:0], 1'b0, rnd[16], rnd[17]};
      adj = rnd[18];
      mb = i[0] ? 0 : rnd[21:19];
      adj_sel <= adj[0];
      mode_bits <= mb[2:0];
      apb(1, 12'h034, {16'h0, fcode[5:0], 10'h0});
      exp_q.push_back(fcode * 1024);
      apb(1, 12'h038, {16'h0, sdata});
      exp_q.push_back(sdata);
      repeat (3) @(posedge mclk);
      #1;
      efine = adj ? fcode : 0;
      ercd = (rcode > 319) ? 319 : rcode;
      chk(fine_code_o, efine, "fine code");
      chk(fine_fs_o, efine * 2300 / 63, "fine delay");
      chk(ref_dly_o, ercd, "ref code");
      chk(ref_ps_o, ercd * 1200 / 319, "ref delay");
      chk(dual_o, sdata[6] && mb == 0, "dual mode");
      chk(phase_o, i[1:0], "phase select");
      chk(slave_o, 1'b0, "role");
      chk({out_dis, drive_n, gate_o}, {sdata[1], sdata[1], sdata[0]}, "out bits");
      apb(0, 12'h034, 0); chk(rd, exp_q.pop_front(), "fine readback");
      apb(0, 12'h038, 0); chk(rd, exp_q.pop_front(), "sync readback");
    end
    // Reference outputs: quarter-rate square when enabled, quiet otherwise
    apb(1, 12'h038, 32'h0001);
    repeat (4) @(posedge mclk);
    hi = 0;
    repeat (8)
    begin
      @(posedge mclk);
      #1;
      hi += out_a;
      chk(out_a, out_b, "out pair");
    end
    chk(hi, 4, "out duty");
    apb(1, 12'h038, 32'h0003);
    repeat (4) @(posedge mclk);
    repeat (8)
    begin
      @(posedge mclk);
      #1;
      chk({out_a, out_b}, 2'b00, "out quiet");
    end
    // Realign pin honoured only with the gate bit cleared
    foreach (ftab[j])
    begin
      if (j < 2)
      begin
        apb(1, 12'h038, j ? 32'h0003 : 32'h0002);
        p0 = n_pulse;
        realign_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        realign_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(n_pulse - p0, j ? 0 : 1, "realign pulses");
      end
    end
    // Master locks alone; slave waits for the master's reference
    chk(aligned, 1'b1, "master aligned");
    apb(1, 12'h038, 32'h001F);
    repeat (4) @(posedge mclk);
    #1;
    chk({slave_o, aligned}, 2'b10, "slave waiting");
    ref_run <= 1'b1;
    n = 0;
    while (aligned !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    chk(aligned, 1'b1, "slave aligned");
    apb(0, 12'h040, 0); chk(rd[0], 1'b1, "status aligned");
    ref_run <= 1'b0;
    end_sim();
  end
endmodule
